// ===== rtl/stc_top.sv
// Sixteen bit timer counter with byte wide register port.
// Assumes a software master per the plain strobe port, one clock domain.
`timescale 1ns/1ns
`default_nettype none
module stc_top (
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  input wire stc_pkg::stc_bus_t BUS_IN,
  output logic [7:0] RDATA_OUT,
  input wire logic EXT_CLK_IN,
  input wire logic SYSCLK_FROM_OSC_IN,
  input wire logic SPECIAL_EVENT_IN,
  output logic OSC_ENABLE_OUT,
  output logic OVERFLOW_OUT
);
  import stc_pkg::*;

  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic [2:0] ext_ff;
  logic ext_raw_prev_ff;
  logic ext_sync_prev_ff;
  logic [1:0] div_ff;
  logic [7:0] ctrl_ff;
  logic [15:0] count_ff;
  logic [15:0] nxt_count;
  logic [7:0] hbuf_ff;
  logic ovf_ff;
  logic sysrun_ff;
  logic [2:0] sys_ff;
  logic ext_edge;
  logic int_tick;
  logic src_tick;
  logic ps_tick;
  logic cnt_tick;
  logic wr_low;
  logic wr_high;
  logic rd_low;
  logic wide;
  logic ctrl_wr;
  logic ovf_clr;

  // Reset release through two flip-flops
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // External pin: three-stage synchroniser, stages two and three compared
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      ext_ff <= 3'h0;
      ext_raw_prev_ff <= 1'b0;
      ext_sync_prev_ff <= 1'b0;
    end else begin
      ext_ff <= {ext_ff[1:0], EXT_CLK_IN};
      ext_raw_prev_ff <= ext_ff[1];
      if (ext_ff[1] == ext_ff[2]) begin
        ext_sync_prev_ff <= ext_ff[2];
      end
    end
  end

  // Rising edge detect, synchronised or bypass path
  always_comb begin
    if (ctrl_ff[STC_BIT_NOSYNC]) begin
      ext_edge = ext_ff[1] && !ext_raw_prev_ff;
    end else begin
      ext_edge = (ext_ff[1] == ext_ff[2]) && ext_ff[2] && !ext_sync_prev_ff;
    end
  end

  // Internal instruction clock: one tick every four system clocks
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= 2'h0;
    end else begin
      div_ff <= div_ff + 2'h1;
    end
  end
  assign int_tick = (div_ff == STC_INT_DIV[1:0]);

  // Source select between pin edges and internal ticks
  assign src_tick = ctrl_ff[STC_BIT_EXT] ? ext_edge : int_tick;
  assign cnt_tick = ps_tick && ctrl_ff[STC_BIT_RUN];

  stc_prescale u_prescale (
    .clk_in(CLK_IN),
    .rst_n_in(rst_n),
    .clr_in(wr_low || wr_high || SPECIAL_EVENT_IN),
    .sel_in(ctrl_ff[STC_BIT_PS_HI:STC_BIT_PS_LO]),
    .tick_in(src_tick && ctrl_ff[STC_BIT_RUN]),
    .tick_out(ps_tick)
  );

  // Register strobe decode; one helper serves every write and low-read strobe match
  function automatic logic hit(input logic strobe, input logic [1:0] addr,
                               input logic [1:0] target);
    hit = strobe && (addr == target);
  endfunction
  assign wide = ctrl_ff[STC_BIT_WIDE];
  assign wr_low = hit(BUS_IN.wr, BUS_IN.addr, STC_ADDR_LOW);
  assign wr_high = hit(BUS_IN.wr, BUS_IN.addr, STC_ADDR_HIGH);
  assign rd_low = hit(BUS_IN.rd, BUS_IN.addr, STC_ADDR_LOW);
  assign ctrl_wr = hit(BUS_IN.wr, BUS_IN.addr, STC_ADDR_CTRL);
  // Status write with bit zero set asks to clear the overflow flag
  assign ovf_clr = hit(BUS_IN.wr, BUS_IN.addr, STC_ADDR_STAT) &&
                   BUS_IN.wdata[STC_BIT_OVF];

  // Control register; status bit is read only
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= STC_CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_ff <= BUS_IN.wdata & ~(8'h01 << STC_BIT_SYSRUN);
    end
  end

  // System clock status: three flops, taken once stages two and three agree
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      sys_ff <= 3'h0;
      sysrun_ff <= 1'b0;
    end else begin
      sys_ff <= {sys_ff[1:0], SYSCLK_FROM_OSC_IN};
      if (sys_ff[2] == sys_ff[1]) begin
        sysrun_ff <= sys_ff[2];
      end
    end
  end

  // Next count: increment, byte writes, then clear
  always_comb begin
    nxt_count = count_ff;
    if (cnt_tick) begin
      nxt_count = count_ff + 16'h0001;
    end
    if (wr_low) begin
      if (wide) begin
        nxt_count = {hbuf_ff, BUS_IN.wdata};
      end else begin
        nxt_count = {nxt_count[15:8], BUS_IN.wdata};
      end
    end
    if (wr_high && !wide) begin
      nxt_count = {BUS_IN.wdata, nxt_count[7:0]};
    end
    if (SPECIAL_EVENT_IN) begin
      nxt_count = STC_COUNT_RST;
    end
  end

  // Count register
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= STC_COUNT_RST;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // High byte buffer: write side and low-read latch
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      hbuf_ff <= 8'h00;
    end else if (wr_high && wide) begin
      hbuf_ff <= BUS_IN.wdata;
    end else if (rd_low && wide) begin
      hbuf_ff <= count_ff[15:8];
    end
  end

  // Overflow flag: set wins over clear
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      ovf_ff <= 1'b0;
    end else if (cnt_tick && count_ff == 16'hFFFF) begin
      ovf_ff <= 1'b1;
    end else if (ovf_clr) begin
      ovf_ff <= 1'b0;
    end
  end

  // Read data, one cycle after the strobe, zero otherwise
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      RDATA_OUT <= 8'h00;
    end else if (BUS_IN.rd) begin
      unique case (BUS_IN.addr)
        STC_ADDR_LOW: RDATA_OUT <= count_ff[7:0];
        STC_ADDR_HIGH: RDATA_OUT <= wide ? hbuf_ff : count_ff[15:8];
        STC_ADDR_CTRL: RDATA_OUT <= ctrl_ff |
                                    (8'(sysrun_ff) << STC_BIT_SYSRUN);
        STC_ADDR_STAT: RDATA_OUT <= {7'h00, ovf_ff};
      endcase
    end else begin
      RDATA_OUT <= 8'h00;
    end
  end

  // Oscillator enable and overflow outputs
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      OSC_ENABLE_OUT <= 1'b0;
      OVERFLOW_OUT <= 1'b0;
    end else begin
      OSC_ENABLE_OUT <= ctrl_ff[STC_BIT_OSC];
      OVERFLOW_OUT <= ovf_ff;
    end
  end

  // Checks on the design's own state; the reset copy disables them
  sequence s_wide_high_wr;
    BUS_IN.wr && BUS_IN.addr == STC_ADDR_HIGH && wide;
  endsequence

  // Overflow clear request that no rollover overrides in the same cycle
  sequence s_ovf_clear;
    ovf_clr && !(cnt_tick && count_ff == 16'hFFFF);
  endsequence

  // Wide low write that no special event overrides
  sequence s_wide_low_wr;
    wr_low && wide && !SPECIAL_EVENT_IN;
  endsequence

  // Special event, run control and plain increment
  a_clear_event: assert property (@(posedge CLK_IN)
    disable iff (!rst_n)
    SPECIAL_EVENT_IN |=> count_ff == 16'h0000)
    else $error("count not cleared by event");

  a_stop_hold: assert property (@(posedge CLK_IN)
    disable iff (!rst_n)
    !ctrl_ff[STC_BIT_RUN] && !BUS_IN.wr && !SPECIAL_EVENT_IN
    |=> $stable(count_ff))
    else $error("count moved while stopped");

  a_run_step: assert property (@(posedge CLK_IN)
    disable iff (!rst_n)
    cnt_tick && !wr_low && !wr_high && !SPECIAL_EVENT_IN
    |=> count_ff == $past(count_ff) + 16'h0001)
    else $error("count did not advance by one");

  // Overflow flag set, hold and clear
  a_overflow_set: assert property (@(posedge CLK_IN)
    disable iff (!rst_n)
    cnt_tick && count_ff == 16'hFFFF |=> ovf_ff ##1 OVERFLOW_OUT)
    else $error("overflow not flagged");

  a_ovf_sticky: assert property (@(posedge CLK_IN)
    disable iff (!rst_n)
    ovf_ff && !ovf_clr |=> ovf_ff)
    else $error("overflow flag dropped");

  a_ovf_clear: assert property (@(posedge CLK_IN)
    disable iff (!rst_n)
    s_ovf_clear |=> !ovf_ff)
    else $error("overflow flag not cleared");

  // Byte and wide access paths
  a_wide_hold: assert property (@(posedge CLK_IN)
    disable iff (!rst_n)
    s_wide_high_wr ##1 !BUS_IN.wr && !SPECIAL_EVENT_IN && !cnt_tick
    |=> $stable(count_ff))
    else $error("wide high write reached count early");

  a_wide_load: assert property (@(posedge CLK_IN)
    disable iff (!rst_n)
    s_wide_low_wr
    |=> count_ff == {$past(hbuf_ff), $past(BUS_IN.wdata)})
    else $error("wide low write did not load both bytes");

  a_low_latch: assert property (@(posedge CLK_IN)
    disable iff (!rst_n)
    rd_low && wide && !BUS_IN.wr |=> hbuf_ff == $past(count_ff[15:8]))
    else $error("low read did not latch high byte");

  a_high_buf_rd: assert property (@(posedge CLK_IN)
    disable iff (!rst_n)
    BUS_IN.rd && BUS_IN.addr == STC_ADDR_HIGH && wide
    |=> RDATA_OUT == $past(hbuf_ff))
    else $error("wide high read not from buffer");

  a_byte_write: assert property (@(posedge CLK_IN)
    disable iff (!rst_n)
    wr_high && !wide && !SPECIAL_EVENT_IN
    |=> count_ff[15:8] == $past(BUS_IN.wdata))
    else $error("high byte write lost");

  a_narrow_low: assert property (@(posedge CLK_IN)
    disable iff (!rst_n)
    wr_low && !wide && !SPECIAL_EVENT_IN
    |=> count_ff[7:0] == $past(BUS_IN.wdata))
    else $error("low byte write lost");

  // Read port behaviour
  a_rdata_idle: assert property (@(posedge CLK_IN)
    disable iff (!rst_n)
    !BUS_IN.rd |=> RDATA_OUT == 8'h00)
    else $error("read data not zero when idle");

  a_rd_status: assert property (@(posedge CLK_IN)
    disable iff (!rst_n)
    BUS_IN.rd && BUS_IN.addr == STC_ADDR_CTRL
    |=> RDATA_OUT[STC_BIT_SYSRUN] == $past(sysrun_ff))
    else $error("status bit not read back");

  a_status_ro: assert property (@(posedge CLK_IN)
    disable iff (!rst_n)
    !ctrl_ff[STC_BIT_SYSRUN])
    else $error("status bit stored as writable");

  a_sysrun_follow: assert property (@(posedge CLK_IN)
    disable iff (!rst_n)
    sys_ff[2] == sys_ff[1] |=> sysrun_ff == $past(sys_ff[2]))
    else $error("clock status not followed");

  // Clock sources and prescaler
  a_int_rate: assert property (@(posedge CLK_IN)
    disable iff (!rst_n)
    int_tick |=> (!int_tick) [*3] ##1 int_tick)
    else $error("internal tick not every four");

  a_ext_sync: assert property (@(posedge CLK_IN)
    disable iff (!rst_n)
    ext_edge && !ctrl_ff[STC_BIT_NOSYNC]
    |-> ext_ff[2] && ext_ff[1] && !ext_sync_prev_ff)
    else $error("synchronised edge before stages agree");

  a_osc_follow: assert property (@(posedge CLK_IN)
    disable iff (!rst_n)
    ##1 OSC_ENABLE_OUT == $past(ctrl_ff[STC_BIT_OSC]))
    else $error("oscillator enable wrong");

  a_div_one: assert property (@(posedge CLK_IN)
    disable iff (!rst_n)
    ctrl_ff[STC_BIT_PS_HI:STC_BIT_PS_LO] == 2'h0 |-> ps_tick == src_tick &&
    ctrl_ff[STC_BIT_RUN] || !ctrl_ff[STC_BIT_RUN])
    else $error("prescale 1:1 dropped tick");
endmodule
`default_nettype wire

// ===== rtl/stc_pkg.sv
// Package for the sixteen bit timer counter: register map, fields, resets.
// Assumes a byte wide register port and a single system clock.
package stc_pkg;
  localparam logic [1:0] STC_ADDR_LOW = 2'h0;
  localparam logic [1:0] STC_ADDR_HIGH = 2'h1;
  localparam logic [1:0] STC_ADDR_CTRL = 2'h2;
  localparam logic [1:0] STC_ADDR_STAT = 2'h3;
  localparam int STC_BIT_WIDE = 7;
  localparam int STC_BIT_SYSRUN = 6;
  localparam int STC_BIT_PS_HI = 5;
  localparam int STC_BIT_PS_LO = 4;
  localparam int STC_BIT_OSC = 3;
  localparam int STC_BIT_NOSYNC = 2;
  localparam int STC_BIT_EXT = 1;
  localparam int STC_BIT_RUN = 0;
  localparam int STC_BIT_OVF = 0;
  localparam logic [7:0] STC_CTRL_RST = 8'h00;
  localparam logic [15:0] STC_COUNT_RST = 16'h0000;
  localparam logic [2:0] STC_INT_DIV = 3'h3;
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } stc_bus_t;
endpackage

// ===== rtl/stc_prescale.sv
// Prescaler for the timer counter: passes one of 1, 2, 4, 8 input ticks.
// Assumes tick_in is a single-cycle pulse on the system clock.
`timescale 1ns/1ns
`default_nettype none
module stc_prescale (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clr_in,
  input wire logic [1:0] sel_in,
  input wire logic tick_in,
  output logic tick_out
);
  logic [2:0] cnt_ff;
  logic [2:0] lim;
  // Terminal count per prescale code
  assign lim = 3'((1 << sel_in) - 1);
  // At or past terminal count, so a code change never stalls the output
  assign tick_out = tick_in && (cnt_ff >= lim);
  // Count input ticks, restart on terminal count or clear
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_ff <= 3'h0;
    end else if (clr_in || tick_out) begin
      cnt_ff <= 3'h0;
    end else if (tick_in) begin
      cnt_ff <= cnt_ff + 3'h1;
    end
  end
endmodule
`default_nettype wire

// ===== verif/stc_ext_src.sv
// Pin side model: external count clock and system clock status level.
// Assumes the bench calls its tasks; the pin stands low outside bursts.
`timescale 1ns/1ns
`default_nettype none
module stc_ext_src (
  output logic pin_out,
  output logic sys_osc_out
);
  // Both lines idle low until the bench asks for activity
  initial begin
    pin_out = 1'b0;
    sys_osc_out = 1'b0;
  end
  // Slow pulses so every rising edge survives the pin synchroniser
  task automatic burst(input int n);
    repeat (n) begin
      #40 pin_out = 1'b1;
      #40 pin_out = 1'b0;
    end
  endtask
  // Level telling whether the system clock runs from the timer oscillator
  task automatic set_sys(input logic lvl);
    sys_osc_out = lvl;
  endtask
endmodule
`default_nettype wire

// ===== verif/stc_top_tb.sv
// Testbench for the timer counter: register tasks and directed tests.
// Assumes the package, design files and pin source model compile first.
`timescale 1ns/1ns
`default_nettype none
module stc_top_tb;
  import stc_pkg::*;
  logic clk, nrst, sev, pin, sys_osc, osc_en, ovf;
  stc_bus_t bus;
  logic [7:0] rdata, v, w;
  int fails, num_checks, n;
  stc_top i_stc_top (.CLK_IN(clk), .NRST_IN(nrst), .BUS_IN(bus),
    .RDATA_OUT(rdata), .EXT_CLK_IN(pin), .SYSCLK_FROM_OSC_IN(sys_osc),
    .SPECIAL_EVENT_IN(sev), .OSC_ENABLE_OUT(osc_en), .OVERFLOW_OUT(ovf));
  stc_ext_src i_stc_ext_src (.pin_out(pin), .sys_osc_out(sys_osc));
  // Free running clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input string what, input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One cycle write strobe
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '{a, d, 1'b0, 1'b0};
  endtask
  // One cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b0};
    #1 d = rdata;
  endtask
  task automatic close_out();
    $display("Checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    nrst = 1'b0;
    sev = 1'b0;
    bus = '0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rd(STC_ADDR_CTRL, v);
    chk("ctrl rst", v, STC_CTRL_RST);
    wr(STC_ADDR_CTRL, 8'hBC);
    rd(STC_ADDR_CTRL, v);
    chk("ctrl", v, 8'hBC);
    chk("osc on", 8'(osc_en), 8'h01);
    i_stc_ext_src.set_sys(1'b1);
    repeat (6) @(posedge clk);
    rd(STC_ADDR_CTRL, v);
    chk("sysrun", v, 8'hFC);
    i_stc_ext_src.set_sys(1'b0);
    wr(STC_ADDR_CTRL, 8'h00);
    wr(STC_ADDR_LOW, 8'hA5);
    wr(STC_ADDR_HIGH, 8'h5A);
    chk("osc off", 8'(osc_en), 8'h00);
    rd(STC_ADDR_LOW, v);
    rd(STC_ADDR_HIGH, w);
    chk("narrow", {v, w} == 16'hA55A ? 8'h01 : 8'h00, 8'h01);
    wr(STC_ADDR_CTRL, 8'h80);
    wr(STC_ADDR_HIGH, 8'h12);
    rd(STC_ADDR_LOW, v);
    rd(STC_ADDR_HIGH, w);
    chk("wide buf", w, 8'h5A);
    wr(STC_ADDR_HIGH, 8'h12);
    wr(STC_ADDR_LOW, 8'h34);
    wr(STC_ADDR_CTRL, 8'h00);
    rd(STC_ADDR_HIGH, w);
    chk("wide wr", w, 8'h12);
    $display("Test regs done");
    // Internal source through each prescale code
    for (int k = 0; k < 4; k++) begin
      wr(STC_ADDR_LOW, 8'h00);
      wr(STC_ADDR_HIGH, 8'h00);
      wr(STC_ADDR_CTRL, {2'h0, k[1:0], 4'h1});
      repeat (64) @(posedge clk);
      wr(STC_ADDR_CTRL, 8'h00);
      rd(STC_ADDR_LOW, v);
      w = 8'(16 >> k);
      chk("prescale", 8'(v + 1 >= w && v <= w + 1), 8'h01);
      repeat (20) @(posedge clk);
      rd(STC_ADDR_LOW, w);
      chk("stopped", w, v);
    end
    $display("Test count done");
    wr(STC_ADDR_LOW, 8'hFF);
    wr(STC_ADDR_HIGH, 8'hFF);
    wr(STC_ADDR_CTRL, 8'h01);
    n = 0;
    while (ovf !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("ovf", 8'(ovf), 8'h01);
    if (n == 40) close_out();
    wr(STC_ADDR_CTRL, 8'h00);
    rd(STC_ADDR_HIGH, v);
    chk("wrap", v, 8'h00);
    rd(STC_ADDR_STAT, v);
    chk("sticky", v, 8'h01);
    wr(STC_ADDR_STAT, 8'h01);
    rd(STC_ADDR_STAT, v);
    chk("cleared", v, 8'h00);
    wr(STC_ADDR_LOW, 8'h77);
    @(posedge clk);
    sev <= 1'b1;
    @(posedge clk);
    sev <= 1'b0;
    rd(STC_ADDR_LOW, v);
    chk("event clr", v, 8'h00);
    $display("Test flag done");
    // Pin edges, synchronised then bypassed
    for (int m = 0; m < 2; m++) begin
      wr(STC_ADDR_LOW, 8'h00);
      wr(STC_ADDR_HIGH, 8'h00);
      wr(STC_ADDR_CTRL, {5'h00, m[0], 2'h3});
      i_stc_ext_src.burst(5);
      repeat (10) @(posedge clk);
      rd(STC_ADDR_LOW, v);
      chk("ext count", v, 8'h05);
    end
    $display("Test ext done");
    close_out();
  end
endmodule
`default_nettype wire
